// ---- design/spi_port_pkg.sv ----
// Purpose: shared constants of the serial peripheral port
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: register offsets, field positions and reset values
package spi_port_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL1 = 8'h00;
    localparam logic [7:0] ADR_CTRL2 = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_DATA = 8'h0c;

    // ------------------------------------------------------------
    // ctrl_primary field positions
    // ------------------------------------------------------------
    localparam int C1_SINGLE = 15;
    localparam int C1_DRIVE = 14;
    localparam int C1_CRC_EN = 13;
    localparam int C1_CRC_NXT = 12;
    localparam int C1_WIDTH = 11;
    localparam int C1_LISTEN = 10;
    localparam int C1_SOFT_SEL = 9;
    localparam int C1_INT_SEL = 8;
    localparam int C1_LOW_LEAD = 7;
    localparam int C1_EN = 6;
    localparam int C1_DIV_HI = 5;
    localparam int C1_DIV_LO = 3;
    localparam int C1_ROLE = 2;
    localparam int C1_IDLE = 1;
    localparam int C1_PHASE = 0;

    // ------------------------------------------------------------
    // ctrl_secondary field positions
    // ------------------------------------------------------------
    localparam int C2_TXE_IE = 7;
    localparam int C2_RX_FULL_FLAG_IE = 6;
    localparam int C2_ERR_IE = 5;
    localparam int C2_SEL_DRV = 2;
    localparam int C2_TX_DMA = 1;
    localparam int C2_RX_DMA = 0;
    localparam logic [7:0] C2_WR_MASK = 8'he7;

    // ------------------------------------------------------------
    // flag_status field positions
    // ------------------------------------------------------------
    localparam int ST_BUSY = 7;
    localparam int ST_OVR = 6;
    localparam int ST_ROLE_FAULT_FLAG = 5;
    localparam int ST_CHECKSUM_MISMATCH_FLAG = 4;
    localparam int ST_TXE = 1;
    localparam int ST_RX_FULL_FLAG = 0;

    // ------------------------------------------------------------
    // reset values and checksum polynomial
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CTRL1 = 16'h0000;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [15:0] RST_STAT = 16'h0002;
    localparam logic [15:0] RST_DATA = 16'h0000;
    localparam logic [15:0] CRC_POLY = 16'h0007;

endpackage

// ---- design/sync_2ff.sv ----
// Purpose: two-flop synchroniser for asynchronous pin inputs
// Assumes: inputs change slowly against clock_i
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_r;

    // ------------------------------------------------------------
    // two stages, constant reset
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule // sync_2ff

`default_nettype wire

// ---- design/serial_peripheral_port_regs.sv ----
// Purpose: register block and transfer engine of a serial port
// Assumes: 125 MHz clock_i, classic Wishbone slave, 2-ff pins
// Notes: checksum polynomial fixed, no checksum readback
//
// Function
// - bit 15 picks one-line or two-line
// - bit 14 sets one-line direction
// - bit 13 enables checksum; change only disabled
// - bit 12 makes next transfer the checksum
// - bit 11 picks 8 or 16-bit frames
// - bit 10 makes two-line port receive-only
// - bit 9 swaps select pin for bit 8
// - bit 7 picks low or high bit first
// - bit 6 enables, bit 2 picks master
// - bits 5:3 divide clock by 2 to 256
// - bit 1 idle clock, bit 0 capture edge
// - control-2 bits 7:5 unmask interrupt requests
// - control-2 bit 2 drives select when master
// - control-2 bits 1:0 raise dma requests
// - busy bit 7; status resets to 0x0002
// - overrun and mode-fault cleared by sequence
// - checksum mismatch flag, cleared by writing 0
// - bit 1 tx empty, bit 0 rx full
// - data register fronts separate tx/rx buffers
// - 8-bit frames use low byte only
// - data read then status read clears overrun
// - status access then ctrl1 write clears fault
// - fault clears enable and master, blocks setting
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module serial_peripheral_port_regs (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic select_in_pin_i,
    output logic select_out_o,
    output logic select_out_oe_o,
    output logic irq_o,
    output logic tx_dma_req_o,
    output logic rx_dma_req_o
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    logic [15:0] tx_buf_r;
    logic [15:0] rx_buf_r;
    logic ovr_r;
    logic role_fault_flag_r;
    logic checksum_mismatch_flag_r;
    logic txe_r;
    logic rx_full_flag_r;
    logic dr_seen_r;
    logic role_fault_flag_arm_r;
    logic act_r;
    logic done_r;
    logic crc_frm_r;
    logic [4:0] edge_idx_r;
    logic [7:0] div_r;
    logic [15:0] tx_sh_r;
    logic [15:0] rx_sh_r;
    logic [15:0] tx_crc_r;
    logic [15:0] rx_crc_r;
    logic sck_prev_r;
    logic [3:0] pins_s;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    sync_2ff #(
        .WIDTH(4)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .d_i({sck_i, mosi_i, miso_i, select_in_pin_i}),
        .q_o(pins_s)
    );

    wire sck_s = pins_s[3];
    wire mosi_s = pins_s[2];
    wire miso_s = pins_s[1];
    wire nsel_s = pins_s[0];

    // ------------------------------------------------------------
    // control field decode
    // ------------------------------------------------------------
    wire single = ctrl1_r[spi_port_pkg::C1_SINGLE];
    wire drive = ctrl1_r[spi_port_pkg::C1_DRIVE];
    wire crc_en = ctrl1_r[spi_port_pkg::C1_CRC_EN];
    wire crc_next = ctrl1_r[spi_port_pkg::C1_CRC_NXT];
    wire w16 = ctrl1_r[spi_port_pkg::C1_WIDTH];
    wire listen = ctrl1_r[spi_port_pkg::C1_LISTEN];
    wire soft_sel = ctrl1_r[spi_port_pkg::C1_SOFT_SEL];
    wire int_sel = ctrl1_r[spi_port_pkg::C1_INT_SEL];
    wire low_lead = ctrl1_r[spi_port_pkg::C1_LOW_LEAD];
    wire en = ctrl1_r[spi_port_pkg::C1_EN];
    wire [2:0] div_sel =
        ctrl1_r[spi_port_pkg::C1_DIV_HI:spi_port_pkg::C1_DIV_LO];
    wire master = ctrl1_r[spi_port_pkg::C1_ROLE];
    wire idle_lvl = ctrl1_r[spi_port_pkg::C1_IDLE];
    wire phase = ctrl1_r[spi_port_pkg::C1_PHASE];

    // ------------------------------------------------------------
    // wishbone decode; one wait state, ack then drop
    // ------------------------------------------------------------
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire half_ok = &wb_sel_i[1:0];
    wire wr = req & wb_we_i & half_ok;
    wire rd = req & ~wb_we_i;
    wire hit_c1 = wb_adr_i == spi_port_pkg::ADR_CTRL1;
    wire hit_c2 = wb_adr_i == spi_port_pkg::ADR_CTRL2;
    wire hit_st = wb_adr_i == spi_port_pkg::ADR_STAT;
    wire hit_dr = wb_adr_i == spi_port_pkg::ADR_DATA;
    wire wr_c1 = wr & hit_c1;
    wire wr_c2 = wr & hit_c2;
    wire wr_st = wr & hit_st;
    wire wr_dr = wr & hit_dr;
    wire rd_st = rd & hit_st;
    wire rd_dr = rd & hit_dr;
    wire acc_st = (wr_st | rd_st);

    // ------------------------------------------------------------
    // mode and select decode
    // ------------------------------------------------------------
    // shared line in one-line mode follows the role
    wire tx_ok = single ? drive : ~listen;
    wire rx_only = single ? ~drive : listen;
    wire rx_ok = ~(single & drive);
    wire rx_bit = single ? (master ? mosi_s : miso_s)
                         : (master ? miso_s : mosi_s);
    wire sel_lvl = soft_sel ? int_sel : nsel_s;
    wire selected = ~sel_lvl;
    wire sel_drv = ctrl2_r[spi_port_pkg::C2_SEL_DRV];
    // select pin is an output when driven, so no fault then
    wire role_fault_flag_evt = en & master & ~sel_drv & ~sel_lvl;

    // ------------------------------------------------------------
    // baud divider: half period of 2^sel cycles
    // ------------------------------------------------------------
    wire [7:0] half_m1 = (8'h01 << div_sel) - 8'h01;
    wire tick = div_r == half_m1;

    // ------------------------------------------------------------
    // edge events from master divider or slave clock pin
    // ------------------------------------------------------------
    wire m_edge = master & act_r & tick;
    wire s_edge = ~master & act_r & selected & (sck_s ^ sck_prev_r);
    wire edge_evt = m_edge | s_edge;
    wire capture = edge_idx_r[0] == phase;
    wire [4:0] last_idx = w16 ? 5'h1f : 5'h0f;
    wire last_edge = edge_evt & (edge_idx_r == last_idx);
    wire shift_now = edge_evt & ~capture
                     & ~(phase & (edge_idx_r == 5'h00));

    // ------------------------------------------------------------
    // frame start and load
    // ------------------------------------------------------------
    wire m_start = en & master & ~act_r & ~done_r & ~role_fault_flag_evt
                   & (~txe_r | rx_only | crc_next);
    wire s_start = en & ~master & ~act_r & ~done_r & selected;
    wire start = m_start | s_start;
    wire use_crc = crc_en & crc_next;
    wire tx_load = start & ~use_crc & ~txe_r;
    wire [15:0] tx_mask = w16 ? 16'hffff : 16'h00ff;
    wire [15:0] load_val = use_crc ? (tx_crc_r & tx_mask)
                         : (txe_r ? 16'h0000 : tx_buf_r);
    wire head = low_lead ? tx_sh_r[0]
              : (w16 ? tx_sh_r[15] : tx_sh_r[7]);

    // ------------------------------------------------------------
    // frame end: received word and its effects
    // ------------------------------------------------------------
    wire [15:0] rx_word = w16 ? rx_sh_r
        : (low_lead ? {8'h00, rx_sh_r[15:8]}
                    : {8'h00, rx_sh_r[7:0]});
    wire rx_done = done_r & rx_ok;
    wire store = rx_done & (~rx_full_flag_r | rd_dr);
    wire ovr_evt = rx_done & rx_full_flag_r & ~rd_dr;
    wire crc_bad = rx_done & crc_frm_r
                   & (rx_word != (rx_crc_r & tx_mask));
    wire busy = en & (act_r | ~txe_r);

    // ------------------------------------------------------------
    // read data mux; reserved bits read zero
    // ------------------------------------------------------------
    wire [15:0] stat_val = {8'h00, busy, ovr_r, role_fault_flag_r, checksum_mismatch_flag_r,
                            2'b00, txe_r, rx_full_flag_r};
    wire [15:0] rd_val = hit_c1 ? ctrl1_r
                       : hit_c2 ? {8'h00, ctrl2_r}
                       : hit_st ? stat_val
                       : hit_dr ? rx_buf_r : 16'h0000;

    // serial checksum step, masked to the frame width
    function automatic logic [15:0] crc_step(
        input logic [15:0] c,
        input logic b,
        input logic wide
    );
        logic fb;
        logic [15:0] n;
        fb = b ^ (wide ? c[15] : c[7]);
        n = {c[14:0], 1'b0}
            ^ (fb ? spi_port_pkg::CRC_POLY : 16'h0000);
        crc_step = wide ? n : {8'h00, n[7:0]};
    endfunction

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= {16'h0000, rd_val};
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // a pending fault blocks enable and master on write
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl1_r <= spi_port_pkg::RST_CTRL1;
            ctrl2_r <= spi_port_pkg::RST_CTRL2;
        end else begin
            if (wr_c1) begin
                ctrl1_r <= wb_dat_i[15:0];
                if (role_fault_flag_r) begin
                    ctrl1_r[spi_port_pkg::C1_EN] <= 1'b0;
                    ctrl1_r[spi_port_pkg::C1_ROLE] <= 1'b0;
                end
            end
            if (start & use_crc) begin
                ctrl1_r[spi_port_pkg::C1_CRC_NXT] <= 1'b0;
            end
            if (role_fault_flag_evt) begin
                ctrl1_r[spi_port_pkg::C1_EN] <= 1'b0;
                ctrl1_r[spi_port_pkg::C1_ROLE] <= 1'b0;
            end
            if (wr_c2) begin
                ctrl2_r <= wb_dat_i[7:0] & spi_port_pkg::C2_WR_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // data buffers and buffer flags
    // ------------------------------------------------------------
    // rx full set wins over a same-cycle data read; a data write wins over a same-cycle tx empty set
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_buf_r <= spi_port_pkg::RST_DATA;
            rx_buf_r <= spi_port_pkg::RST_DATA;
            txe_r <= spi_port_pkg::RST_STAT[spi_port_pkg::ST_TXE];
            rx_full_flag_r <= 1'b0;
        end else begin
            if (wr_dr) begin
                tx_buf_r <= wb_dat_i[15:0] & tx_mask;
                txe_r <= 1'b0;
            end else if (tx_load) begin
                txe_r <= 1'b1;
            end
            if (store) begin
                rx_buf_r <= rx_word;
                rx_full_flag_r <= 1'b1;
            end else if (rd_dr) begin
                rx_full_flag_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // error flags and their clearing sequences
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ovr_r <= 1'b0;
            role_fault_flag_r <= 1'b0;
            checksum_mismatch_flag_r <= 1'b0;
            dr_seen_r <= 1'b0;
            role_fault_flag_arm_r <= 1'b0;
        end else begin
            if (rd_dr) begin
                dr_seen_r <= 1'b1;
            end else if (rd_st) begin
                dr_seen_r <= 1'b0;
            end
            if (ovr_evt) begin
                ovr_r <= 1'b1;
            end else if (rd_st & dr_seen_r) begin
                ovr_r <= 1'b0;
            end
            if (acc_st & role_fault_flag_r) begin
                role_fault_flag_arm_r <= 1'b1;
            end else if (wr_c1) begin
                role_fault_flag_arm_r <= 1'b0;
            end
            if (role_fault_flag_evt) begin
                role_fault_flag_r <= 1'b1;
            end else if (wr_c1 & role_fault_flag_arm_r) begin
                role_fault_flag_r <= 1'b0;
            end
            if (crc_bad) begin
                checksum_mismatch_flag_r <= 1'b1;
            end else if (wr_st & ~wb_dat_i[spi_port_pkg::ST_CHECKSUM_MISMATCH_FLAG]) begin
                checksum_mismatch_flag_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // frame sequencer and baud counter
    // ------------------------------------------------------------
    // disable or deselect aborts the frame in flight
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            act_r <= 1'b0;
            done_r <= 1'b0;
            crc_frm_r <= 1'b0;
            edge_idx_r <= 5'h00;
            div_r <= 8'h00;
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_s;
            done_r <= last_edge;
            if (~en | role_fault_flag_evt | (~master & ~selected)) begin
                act_r <= 1'b0;
            end else if (start) begin
                act_r <= 1'b1;
                crc_frm_r <= use_crc;
            end else if (last_edge) begin
                act_r <= 1'b0;
            end
            if (start | ~act_r) begin
                edge_idx_r <= 5'h00;
                div_r <= 8'h00;
            end else begin
                if (edge_evt) begin
                    edge_idx_r <= edge_idx_r + 5'h01;
                end
                div_r <= tick ? 8'h00 : div_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // shift registers and running checksums
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sh_r <= spi_port_pkg::RST_DATA;
            rx_sh_r <= spi_port_pkg::RST_DATA;
            tx_crc_r <= 16'h0000;
            rx_crc_r <= 16'h0000;
        end else begin
            if (start) begin
                tx_sh_r <= load_val;
            end else if (shift_now) begin
                tx_sh_r <= low_lead ? {1'b0, tx_sh_r[15:1]}
                                    : {tx_sh_r[14:0], 1'b0};
            end
            if (edge_evt & capture) begin
                rx_sh_r <= low_lead ? {rx_bit, rx_sh_r[15:1]}
                                    : {rx_sh_r[14:0], rx_bit};
            end
            if (wr_c1 & wb_dat_i[spi_port_pkg::C1_CRC_EN]) begin
                tx_crc_r <= 16'h0000;
                rx_crc_r <= 16'h0000;
            end else if (edge_evt & capture & crc_en & ~crc_frm_r) begin
                tx_crc_r <= crc_step(tx_crc_r, head, w16);
                rx_crc_r <= crc_step(rx_crc_r, rx_bit, w16);
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers, all registered
    // ------------------------------------------------------------
    // outputs lag internal state by one cycle for clean timing
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sck_o <= 1'b0;
            sck_oe_o <= 1'b0;
            mosi_o <= 1'b0;
            mosi_oe_o <= 1'b0;
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
            select_out_o <= 1'b1;
            select_out_oe_o <= 1'b0;
        end else begin
            if (~(master & act_r)) begin
                sck_o <= idle_lvl;
            end else if (m_edge) begin
                sck_o <= ~sck_o;
            end
            sck_oe_o <= en & master;
            mosi_o <= head;
            mosi_oe_o <= en & master & tx_ok;
            miso_o <= head;
            miso_oe_o <= en & ~master & selected & tx_ok;
            select_out_o <= ~(en & master);
            select_out_oe_o <= en & master & sel_drv;
        end
    end

    // ------------------------------------------------------------
    // interrupt and dma requests, level while source set
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            tx_dma_req_o <= 1'b0;
            rx_dma_req_o <= 1'b0;
        end else begin
            irq_o <= (ctrl2_r[spi_port_pkg::C2_TXE_IE] & txe_r)
                   | (ctrl2_r[spi_port_pkg::C2_RX_FULL_FLAG_IE] & rx_full_flag_r)
                   | (ctrl2_r[spi_port_pkg::C2_ERR_IE]
                      & (ovr_r | role_fault_flag_r | checksum_mismatch_flag_r));
            tx_dma_req_o <= ctrl2_r[spi_port_pkg::C2_TX_DMA]
                            & txe_r;
            rx_dma_req_o <= ctrl2_r[spi_port_pkg::C2_RX_DMA]
                            & rx_full_flag_r;
        end
    end

endmodule // serial_peripheral_port_regs

`default_nettype wire

// ---- tb/spi_regs_checker.sv ----
// Purpose: port-level checks of the serial port block
// Assumes: sees top-level ports only
// Notes: bound into every instance
`timescale 1ns/1ps
`default_nettype none
module spi_regs_checker (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic sck_oe_o,
    input wire logic mosi_oe_o,
    input wire logic miso_oe_o,
    input wire logic select_out_o,
    input wire logic select_out_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // ----
    // bus answer and pin ownership
    // ----
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_req |=> s_ans; endproperty
    property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
    property p_seldrv; select_out_oe_o |-> sck_oe_o; endproperty
    property p_sellow; select_out_oe_o |-> !select_out_o; endproperty
    property p_selidle; !sck_oe_o |-> select_out_o; endproperty
    property p_role; miso_oe_o |-> !sck_oe_o; endproperty
    property p_mosi; mosi_oe_o |-> sck_oe_o; endproperty
    a_ack: assert property (p_ack) else $error("ack");
    a_cause: assert property (p_cause) else $error("stray ack");
    a_hi: assert property (p_hi) else $error("high half");
    a_seldrv: assert property (p_seldrv) else $error("sel drv");
    a_sellow: assert property (p_sellow) else $error("sel lvl");
    a_selidle: assert property (p_selidle) else $error("sel idle");
    a_role: assert property (p_role) else $error("role");
    a_mosi: assert property (p_mosi) else $error("mosi");
endmodule // spi_regs_checker
bind serial_peripheral_port_regs spi_regs_checker i_chk (
    .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o),
    .select_out_o(select_out_o), .select_out_oe_o(select_out_oe_o));
`default_nettype wire

// ---- tb/spi_peer_model.sv ----
// Purpose: far-side peer answering a master frame
// Assumes: idle-low clock, capture on rising edge, msb first
// Notes: sends a fixed byte, keeps what it receives
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic sel_n_i,
    output logic miso_o,
    output logic [7:0] got_o
);
    logic [7:0] sh_r = 8'ha5;
    // deselected line shows the inverse, never a stale bit
    assign miso_o = sel_n_i ? ~sh_r[7] : sh_r[7];
    // capture on rising edge, shift on falling edge
    always @(posedge sck_i) got_o <= {got_o[6:0], mosi_i};
    // deselected: the unknown-to-idle clock step after reset must not rotate
    always @(negedge sck_i)
        if (!sel_n_i) sh_r <= {sh_r[6:0], sh_r[7]};
endmodule // spi_peer_model
`default_nettype wire

// ---- tb/serial_peripheral_port_regs_bench.sv ----
// Purpose: self-checking bench of the serial port registers
// Assumes: classic single-cycle bus master, 8 ns clock
// Notes: far side is a peer model answering master frames
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_port_regs_bench;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] got;
    logic [31:0] wd = 32'h0;
    logic [31:0] q, dat;
    logic ack, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, so, so_oe;
    logic irq, txd, rxd;
    int n_mismatch = 0;
    int n_checks = 0;
    int ticks = 0;
    always #4 clock_i = ~clock_i;
    // undriven pins fall to idle or pulled-up levels
    wire sck_w = sck_oe ? sck : 1'b0;
    wire mosi_w = mosi_oe ? mosi : 1'b1;
    wire sel_w = so_oe ? so : 1'b1;
    serial_peripheral_port_regs i_dut (.clock_i(clock_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_ack_o(ack), .wb_dat_o(dat),
        .sck_i(1'b0), .sck_o(sck), .sck_oe_o(sck_oe), .mosi_i(1'b0),
        .mosi_o(mosi), .mosi_oe_o(mosi_oe), .miso_i(miso), .miso_o(),
        .miso_oe_o(miso_oe), .select_in_pin_i(1'b1), .select_out_o(so),
        .select_out_oe_o(so_oe), .irq_o(irq), .tx_dma_req_o(txd),
        .rx_dma_req_o(rxd));
    spi_peer_model i_peer (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(sel_w),
        .miso_o(miso), .got_o(got));
    // one bus cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
        @(posedge clock_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clock_i); while (ack !== 1'b1);
        q = dat;
        cyc <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic t_reset;
        bus(0, 8'h00, 0); chk(q, 32'h0);
        bus(0, 8'h08, 0); chk(q, 32'h2);
        bus(0, 8'h0c, 0); chk(q, 32'h0);
        bus(0, 8'h10, 0); chk(q, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_ctrl2;
        bus(1, 8'h04, 32'hffff);
        bus(0, 8'h04, 0); chk(q, 32'he7);
        chk({31'h0, irq}, 32'h1);
        chk({30'h0, txd, rxd}, 32'h2);
        bus(1, 8'h04, 0);
        @(negedge clock_i);
        chk({29'h0, irq, txd, rxd}, 32'h0);
        $display("enable test done");
    endtask
    task automatic t_xfer;
        bus(1, 8'h04, 32'h4);
        bus(1, 8'h00, 32'h035c);
        bus(1, 8'h0c, 32'h3c);
        bus(0, 8'h08, 0); chk({31'h0, q[7]}, 32'h1);
        do bus(0, 8'h08, 0); while (q[0] !== 1'b1);
        chk(q, 32'h3);
        chk({24'h0, got}, 32'h3c);
        bus(0, 8'h0c, 0); chk(q, 32'ha5);
        bus(0, 8'h08, 0); chk(q, 32'h2);
        bus(1, 8'h00, 0);
        bus(1, 8'h04, 0);
        $display("transfer test done");
    endtask
    task automatic t_crc;
        bus(1, 8'h04, 32'h4);
        bus(1, 8'h00, 32'h231c);
        bus(1, 8'h00, 32'h235c);
        bus(1, 8'h0c, 32'h3c);
        bus(1, 8'h00, 32'h335c);
        do bus(0, 8'h08, 0); while (q[0] !== 1'b1);
        bus(0, 8'h0c, 0); chk(q, 32'ha5);
        do bus(0, 8'h08, 0); while (q[0] !== 1'b1);
        chk(q, 32'h13);
        chk({24'h0, got}, 32'hb4);
        bus(0, 8'h00, 0); chk(q, 32'h235c);
        bus(1, 8'h08, 32'h10);
        bus(0, 8'h08, 0); chk(q, 32'h13);
        bus(1, 8'h08, 0);
        bus(0, 8'h08, 0); chk(q, 32'h3);
        bus(0, 8'h0c, 0); chk(q, 32'ha5);
        bus(1, 8'h00, 0);
        bus(1, 8'h04, 0);
        $display("checksum test done");
    endtask
    task automatic t_fault;
        bus(1, 8'h00, 32'h025c);
        bus(0, 8'h00, 0); chk(q, 32'h0218);
        bus(0, 8'h08, 0); chk(q, 32'h22);
        bus(1, 8'h00, 0);
        bus(0, 8'h08, 0); chk(q, 32'h2);
        bus(1, 8'h00, 32'h0240);
        @(negedge clock_i);
        chk({31'h0, miso_oe}, 32'h1);
        bus(1, 8'h00, 0);
        $display("fault test done");
    endtask
    // the cycle ceiling cuts a hang short
    always @(posedge clock_i) begin
        ticks <= ticks + 1;
        if (ticks == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_ctrl2();
        t_xfer();
        t_crc();
        t_fault();
        report_and_stop();
    end
endmodule // serial_peripheral_port_regs_bench
`default_nettype wire
